// ### core/usb_phy_interface_regs.sv
// register-controlled otg, serial line and flag logic facing the transceiver
`timescale 1ns/1ps

module usb_phy_interface_regs
    import usb_phy_regs_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    input  wire logic [7:0]    reg_addr_i,
    input  wire logic [31:0]   reg_wdata_i,
    output logic      [31:0]   reg_rdata_o,
    output logic               reg_rvalid_o,
    input  wire logic [6:0]    device_address_i,
    input  wire utmi_status_t  utmi_status_i,
    input  wire packet_event_t pkt_i,
    output utmi_ctrl_t         utmi_ctrl_o,
    output logic      [4:0]    rx_endpoint_o,
    output logic               rx_endpoint_valid_o,
    output logic               flag_port_a_o,
    output logic               flag_port_b_o,
    output logic               flag_port_c_o,
    output logic               flag_port_d_o
);

    ////////////////////////////////////////////////////////////////////////////
    // transceiver input synchronisers

    utmi_status_t sync1_q;
    utmi_status_t sync2_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= utmi_status_i;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access decode

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    wire wr_reset  = reg_wr_i && hit(reg_addr_i, OFS_MODULE_RESET);
    wire wr_otg    = reg_wr_i && hit(reg_addr_i, OFS_OTG_POWER_CONTROL);
    wire wr_serial = reg_wr_i && hit(reg_addr_i, OFS_SERIAL_LINE_CTRL);
    wire wr_flags  = reg_wr_i && hit(reg_addr_i, OFS_LINE_ERROR_FLAGS);
    wire wr_hold   = reg_wr_i && hit(reg_addr_i, OFS_FLAG_HOLD_SELECT);
    wire wr_route  = reg_wr_i && hit(reg_addr_i, OFS_FLAG_PORT_ROUTING);
    wire wr_frame  = reg_wr_i && hit(reg_addr_i, OFS_FRAME_NUMBER);
    wire wr_mark   = reg_wr_i && hit(reg_addr_i, OFS_ENDPOINT_MARK);
    wire wr_omask  = reg_wr_i && hit(reg_addr_i, OFS_OTG_STATUS_MASK);
    wire wr_power  = reg_wr_i && hit(reg_addr_i, OFS_POWER_SIGNAL_WORD);

    ////////////////////////////////////////////////////////////////////////////
    // software registers; a module reset write clears them like power-on

    logic [7:0]  otg_ctrl_q;
    logic [3:0]  serial_ctrl_q;
    logic [6:0]  hold_sel_q;
    logic [31:0] route_q;
    logic [10:0] frame_q;
    logic [15:0] ep_mark_q;
    logic [31:0] otg_mask_q;
    logic [8:0]  power_word_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            otg_ctrl_q    <= RST_OTG_POWER_CONTROL;
            serial_ctrl_q <= RST_SERIAL_LINE_CTRL;
            hold_sel_q    <= RST_FLAGS;
            route_q       <= '0;
            frame_q       <= RST_FRAME_NUMBER;
            ep_mark_q     <= '0;
            otg_mask_q    <= '0;
            power_word_q  <= RST_POWER_SIGNAL_WORD;
        end else if (wr_reset) begin
            otg_ctrl_q    <= RST_OTG_POWER_CONTROL;
            serial_ctrl_q <= RST_SERIAL_LINE_CTRL;
            hold_sel_q    <= RST_FLAGS;
            route_q       <= '0;
            frame_q       <= RST_FRAME_NUMBER;
            ep_mark_q     <= '0;
            otg_mask_q    <= '0;
            power_word_q  <= RST_POWER_SIGNAL_WORD;
        end else begin
            // bit 5 is reserved and never stored
            if (wr_otg)    otg_ctrl_q    <= reg_wdata_i[7:0] & 8'hdf;
            if (wr_serial) serial_ctrl_q <= reg_wdata_i[3:0];
            if (wr_hold)   hold_sel_q    <= reg_wdata_i[6:0];
            if (wr_route)  route_q       <= reg_wdata_i;
            // software write wins over a frame number from the line
            if (wr_frame)  frame_q       <= reg_wdata_i[10:0];
            else if (pkt_i.sof_valid) frame_q <= pkt_i.sof_frame;
            if (wr_mark)   ep_mark_q     <= reg_wdata_i[15:0];
            if (wr_omask)  otg_mask_q    <= reg_wdata_i;
            if (wr_power)  power_word_q  <= reg_wdata_i[8:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // packet capture

    wire addr_match = (pkt_i.token_address == device_address_i);
    wire token_good = pkt_i.token_done && pkt_i.token_crc5_ok
                      && pkt_i.token_pid_ok && addr_match;

    logic [3:0] last_pid_q;
    logic [3:0] last_ep_q;
    logic       ep_valid_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_pid_q <= '0;
            last_ep_q  <= '0;
            ep_valid_q <= 1'b0;
        end else if (wr_reset) begin
            last_pid_q <= '0;
            last_ep_q  <= '0;
            ep_valid_q <= 1'b0;
        end else begin
            if (pkt_i.pid_valid) last_pid_q <= pkt_i.pid;
            if (token_good) begin
                last_ep_q  <= pkt_i.token_endpoint;
                ep_valid_q <= 1'b1;
            end
        end
    end

    wire ep_marked = ep_mark_q[last_ep_q];
    wire [4:0] ep_out = {1'b0, last_ep_q} | (ep_marked ? EP_MARK_OR : 5'h00);

    ////////////////////////////////////////////////////////////////////////////
    // line and error flags

    // level sources are followed while not held; event sources set and wait
    logic [6:0] flag_src;
    assign flag_src[FLG_TOKEN_OK]   = token_good;
    assign flag_src[FLG_SE0]        = (sync2_q.line_state == LS_SE0);
    assign flag_src[FLG_K]          = (sync2_q.line_state == LS_K);
    assign flag_src[FLG_J]          = (sync2_q.line_state == LS_J);
    assign flag_src[FLG_CRC16_FAIL] = pkt_i.data_crc16_fail;
    assign flag_src[FLG_RX_ACTIVE]  = sync2_q.receive_active_input;
    assign flag_src[FLG_RX_ERROR]   = sync2_q.receive_error_input;

    localparam logic [6:0] LEVEL_FLAGS = 7'h3b;

    logic [6:0] flags_q;
    logic [6:0] flags_d;
    wire  [6:0] w1c = wr_flags ? reg_wdata_i[6:0] : 7'h00;

    always_comb begin
        for (int i = 0; i < FLAG_WIDTH; i++) begin
            if (hold_sel_q[i]) begin
                // set wins over a clear in the same cycle
                flags_d[i] = flag_src[i] | (flags_q[i] & ~w1c[i]);
            end else if (LEVEL_FLAGS[i]) begin
                flags_d[i] = flag_src[i];
            end else begin
                flags_d[i] = flag_src[i] | (flags_q[i] & ~w1c[i]
                             & ~pkt_i.packet_start);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) flags_q <= RST_FLAGS;
        else if (wr_reset) flags_q <= RST_FLAGS;
        else flags_q <= flags_d;
    end

    function automatic logic routed(input logic [7:0] mask, input logic [6:0] f);
        routed = |(mask[6:0] & f);
    endfunction : routed

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_port_a_o       <= 1'b0;
            flag_port_b_o       <= 1'b0;
            flag_port_c_o       <= 1'b0;
            flag_port_d_o       <= 1'b0;
            rx_endpoint_o       <= '0;
            rx_endpoint_valid_o <= 1'b0;
        end else begin
            flag_port_a_o       <= routed(route_q[MASK_A_LSB +: 8], flags_q);
            flag_port_b_o       <= routed(route_q[MASK_B_LSB +: 8], flags_q);
            flag_port_c_o       <= routed(route_q[MASK_C_LSB +: 8], flags_q);
            flag_port_d_o       <= routed(route_q[MASK_D_LSB +: 8], flags_q);
            rx_endpoint_o       <= ep_out;
            rx_endpoint_valid_o <= ep_valid_q;
        end
    end

    assign utmi_ctrl_o.external_bus_voltage_indication = otg_ctrl_q[OTG_EXT_VBUS_IND_BIT];
    assign utmi_ctrl_o.drive_bus_voltage_external      = otg_ctrl_q[OTG_DRV_VBUS_EXT_BIT];
    assign utmi_ctrl_o.bus_charge_request              = otg_ctrl_q[OTG_CHARGE_BIT];
    assign utmi_ctrl_o.bus_discharge_request           = otg_ctrl_q[OTG_DISCHARGE_BIT];
    assign utmi_ctrl_o.minus_line_pulldown             = otg_ctrl_q[OTG_DM_PULLDOWN_BIT];
    assign utmi_ctrl_o.plus_line_pulldown              = otg_ctrl_q[OTG_DP_PULLDOWN_BIT];
    assign utmi_ctrl_o.id_pin_pullup                   = otg_ctrl_q[OTG_ID_PULLUP_BIT];
    assign utmi_ctrl_o.transmit_single_ended_zero      = serial_ctrl_q[SER_TX_SE0_BIT];
    assign utmi_ctrl_o.serial_transmit_value           = serial_ctrl_q[SER_TX_DATA_BIT];
    assign utmi_ctrl_o.transmit_enable_low             = serial_ctrl_q[SER_TX_EN_N_BIT];
    assign utmi_ctrl_o.full_low_speed_serial_mode      = serial_ctrl_q[SER_FSLS_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped and write-only offsets read zero

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_addr_i)
            OFS_OTG_POWER_CONTROL: rd_mux = {24'h00_0000, otg_ctrl_q};
            OFS_OTG_STATUS_MIRROR: rd_mux = {26'h000_0000, sync2_q.otg};
            OFS_SERIAL_LINE_CTRL:  rd_mux = {25'h000_0000,
                                             sync2_q.differential_receive_value,
                                             sync2_q.minus_line_receive,
                                             sync2_q.plus_line_receive,
                                             serial_ctrl_q};
            OFS_LINE_ERROR_FLAGS:  rd_mux = {25'h000_0000, flags_q};
            OFS_FLAG_HOLD_SELECT:  rd_mux = {25'h000_0000, hold_sel_q};
            OFS_FLAG_PORT_ROUTING: rd_mux = route_q;
            OFS_FRAME_NUMBER:      rd_mux = {21'h00_0000, frame_q};
            OFS_LAST_PACKET_ID:    rd_mux = {28'h000_0000, last_pid_q};
            OFS_LAST_ENDPOINT:     rd_mux = {27'h000_0000, ep_valid_q, last_ep_q};
            OFS_ENDPOINT_MARK:     rd_mux = {16'h0000, ep_mark_q};
            OFS_OTG_STATUS_MASK:   rd_mux = otg_mask_q;
            OFS_POWER_SIGNAL_WORD: rd_mux = {23'h00_0000, power_word_q};
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // whole-word accesses only; no byte lanes are decoded
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) reg_rdata_o <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_otg_drive;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_otg && !wr_reset |=> utmi_ctrl_o.bus_charge_request == $past(reg_wdata_i[4])
            && utmi_ctrl_o.external_bus_voltage_indication == $past(reg_wdata_i[7]);
    endproperty
    a_otg_drive: assert property (p_otg_drive)
        else $error("otg control write not driven to transceiver");

    property p_pulldown;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_otg |=> utmi_ctrl_o.minus_line_pulldown == $past(reg_wdata_i[2]);
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("minus line pulldown mismatch");

    property p_status_mirror;
        @(posedge clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == OFS_OTG_STATUS_MIRROR
            |=> reg_rvalid_o && reg_rdata_o[5:0] == $past(sync2_q.otg);
    endproperty
    a_status_mirror: assert property (p_status_mirror)
        else $error("otg status read does not mirror inputs");

    property p_tx_enable_reset;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_reset |=> utmi_ctrl_o.transmit_enable_low && !utmi_ctrl_o.full_low_speed_serial_mode;
    endproperty
    a_tx_enable_reset: assert property (p_tx_enable_reset)
        else $error("serial control not at reset value after module reset");

    property p_token_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
        token_good && !wr_reset |=> flags_q[FLG_TOKEN_OK];
    endproperty
    a_token_flag: assert property (p_token_flag)
        else $error("good token did not set flag");

    property p_bad_address;
        @(posedge clk_i) disable iff (!rst_n_i)
        pkt_i.token_done && !addr_match |=> $stable(last_ep_q);
    endproperty
    a_bad_address: assert property (p_bad_address)
        else $error("foreign token updated endpoint");

    property p_held_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
        hold_sel_q[FLG_CRC16_FAIL] && flags_q[FLG_CRC16_FAIL] && !w1c[FLG_CRC16_FAIL]
            && !wr_reset && !wr_hold |=> flags_q[FLG_CRC16_FAIL];
    endproperty
    a_held_flag: assert property (p_held_flag)
        else $error("held flag dropped without clear");

    property p_packet_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        !hold_sel_q[FLG_CRC16_FAIL] && pkt_i.packet_start && !pkt_i.data_crc16_fail
            |=> !flags_q[FLG_CRC16_FAIL];
    endproperty
    a_packet_clear: assert property (p_packet_clear)
        else $error("unheld flag survived next packet");

    property p_port_route;
        @(posedge clk_i) disable iff (!rst_n_i)
        |(route_q[6:0] & flags_q) |=> flag_port_a_o;
    endproperty
    a_port_route: assert property (p_port_route)
        else $error("routed flag did not raise port");

    property p_rx_follow;
        @(posedge clk_i) disable iff (!rst_n_i)
        !hold_sel_q[FLG_RX_ACTIVE] && !wr_reset
            |=> flags_q[FLG_RX_ACTIVE] == $past(sync2_q.receive_active_input);
    endproperty
    a_rx_follow: assert property (p_rx_follow)
        else $error("rx active flag does not follow input");

    property p_ep_mark;
        @(posedge clk_i) disable iff (!rst_n_i)
        ep_marked |=> rx_endpoint_o[4];
    endproperty
    a_ep_mark: assert property (p_ep_mark)
        else $error("marked endpoint missing 0x10");

    property p_crc16_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
        pkt_i.data_crc16_fail && !wr_reset |=> flags_q[FLG_CRC16_FAIL];
    endproperty
    a_crc16_flag: assert property (p_crc16_flag)
        else $error("data crc failure did not set flag");

    property p_pid_capture;
        @(posedge clk_i) disable iff (!rst_n_i)
        pkt_i.pid_valid && !wr_reset |=> last_pid_q == $past(pkt_i.pid);
    endproperty
    a_pid_capture: assert property (p_pid_capture)
        else $error("packet identifier not captured");

    property p_frame_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_frame |=> frame_q == $past(reg_wdata_i[10:0]);
    endproperty
    a_frame_write: assert property (p_frame_write)
        else $error("frame number write not stored");

    property p_otg_reserved;
        @(posedge clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == OFS_OTG_POWER_CONTROL
            |=> reg_rdata_o[31:8] == 24'h00_0000 && !reg_rdata_o[5];
    endproperty
    a_otg_reserved: assert property (p_otg_reserved)
        else $error("reserved otg control bits read nonzero");

endmodule : usb_phy_interface_regs

// ### core/usb_phy_regs_pkg.sv
// constants, field layouts and carrier types for the phy interface register block
package usb_phy_regs_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_MODULE_RESET       = 8'h00;
    localparam logic [7:0] OFS_OTG_POWER_CONTROL  = 8'h10;
    localparam logic [7:0] OFS_OTG_STATUS_MIRROR  = 8'h14;
    localparam logic [7:0] OFS_SERIAL_LINE_CTRL   = 8'h18;
    localparam logic [7:0] OFS_LINE_ERROR_FLAGS   = 8'h1c;
    localparam logic [7:0] OFS_FLAG_HOLD_SELECT   = 8'h20;
    localparam logic [7:0] OFS_FLAG_PORT_ROUTING  = 8'h24;
    localparam logic [7:0] OFS_FRAME_NUMBER       = 8'h28;
    localparam logic [7:0] OFS_LAST_PACKET_ID     = 8'h2c;
    localparam logic [7:0] OFS_LAST_ENDPOINT      = 8'h30;
    localparam logic [7:0] OFS_ENDPOINT_MARK      = 8'h34;
    localparam logic [7:0] OFS_OTG_STATUS_MASK    = 8'h38;
    localparam logic [7:0] OFS_POWER_SIGNAL_WORD  = 8'h3c;

    // otg power control field positions
    localparam int OTG_EXT_VBUS_IND_BIT = 7;
    localparam int OTG_DRV_VBUS_EXT_BIT = 6;
    localparam int OTG_CHARGE_BIT       = 4;
    localparam int OTG_DISCHARGE_BIT    = 3;
    localparam int OTG_DM_PULLDOWN_BIT  = 2;
    localparam int OTG_DP_PULLDOWN_BIT  = 1;
    localparam int OTG_ID_PULLUP_BIT    = 0;

    // serial line control field positions
    localparam int SER_DIFF_RX_BIT  = 6;
    localparam int SER_DM_RX_BIT    = 5;
    localparam int SER_DP_RX_BIT    = 4;
    localparam int SER_TX_SE0_BIT   = 3;
    localparam int SER_TX_DATA_BIT  = 2;
    localparam int SER_TX_EN_N_BIT  = 1;
    localparam int SER_FSLS_BIT     = 0;

    // line error flag positions
    localparam int FLG_TOKEN_OK     = 6;
    localparam int FLG_SE0          = 5;
    localparam int FLG_K            = 4;
    localparam int FLG_J            = 3;
    localparam int FLG_CRC16_FAIL   = 2;
    localparam int FLG_RX_ACTIVE    = 1;
    localparam int FLG_RX_ERROR     = 0;
    localparam int FLAG_WIDTH       = 7;

    // port routing mask positions
    localparam int MASK_A_LSB = 0;
    localparam int MASK_B_LSB = 8;
    localparam int MASK_C_LSB = 16;
    localparam int MASK_D_LSB = 24;

    // endpoint valid bit and mark value
    localparam int         EP_VALID_BIT = 4;
    localparam logic [4:0] EP_MARK_OR   = 5'h10;

    // reset values
    localparam logic [7:0]  RST_OTG_POWER_CONTROL = 8'h00;
    localparam logic [3:0]  RST_SERIAL_LINE_CTRL  = 4'h2;
    localparam logic [6:0]  RST_FLAGS             = 7'h00;
    localparam logic [10:0] RST_FRAME_NUMBER      = 11'h000;
    localparam logic [8:0]  RST_POWER_SIGNAL_WORD = 9'h000;

    // line state encodings
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J   = 2'h1;
    localparam logic [1:0] LS_K   = 2'h2;

    // transceiver status inputs, bit order matches the otg status mirror
    typedef struct packed {
        logic       b_session_valid;
        logic       id_grounded;
        logic       host_disconnect;
        logic       bus_voltage_valid;
        logic       session_valid;
        logic       session_end;
    } otg_status_t;

    typedef struct packed {
        otg_status_t otg;
        logic        differential_receive_value;
        logic        minus_line_receive;
        logic        plus_line_receive;
        logic        receive_active_input;
        logic        receive_error_input;
        logic [1:0]  line_state;
    } utmi_status_t;

    // controls driven toward the transceiver
    typedef struct packed {
        logic external_bus_voltage_indication;
        logic drive_bus_voltage_external;
        logic bus_charge_request;
        logic bus_discharge_request;
        logic minus_line_pulldown;
        logic plus_line_pulldown;
        logic id_pin_pullup;
        logic transmit_single_ended_zero;
        logic serial_transmit_value;
        logic transmit_enable_low;
        logic full_low_speed_serial_mode;
    } utmi_ctrl_t;

    // events from the packet decoder, same clock
    typedef struct packed {
        logic        packet_start;
        logic        token_done;
        logic        token_crc5_ok;
        logic        token_pid_ok;
        logic [6:0]  token_address;
        logic [3:0]  token_endpoint;
        logic        pid_valid;
        logic [3:0]  pid;
        logic        data_crc16_fail;
        logic        sof_valid;
        logic [10:0] sof_frame;
    } packet_event_t;

endpackage : usb_phy_regs_pkg

// ### tb/usb_phy_interface_regs_tb_top.sv
// register sequence tests for the phy interface register block
`timescale 1ns/1ps
module usb_phy_interface_regs_tb_top;
    import usb_phy_regs_pkg::*;
    logic          clk_i = 0, rst_n_i = 0, wr = 0, rd = 0;
    logic [7:0]    addr = 8'h00;
    logic [31:0]   wdata = 32'h0000_0000, rdata;
    logic          rvalid, pa, pb, pc, pd, epv;
    logic [4:0]    ep;
    logic [5:0]    otg = 6'h00;
    logic [1:0]    rx = 2'h0;
    packet_event_t pk = '0;
    utmi_status_t  st;
    utmi_ctrl_t    ctrl;
    int            errors = 0, comparisons = 0, cycles = 0;
    initial forever #5 clk_i = ~clk_i;
    usb_xcvr_model xcvr_u (.ctrl_i(ctrl), .otg_i(otg), .rx_i(rx), .status_o(st));
    usb_phy_interface_regs dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .device_address_i(7'h2a), .utmi_status_i(st), .pkt_i(pk),
        .utmi_ctrl_o(ctrl), .rx_endpoint_o(ep), .rx_endpoint_valid_o(epv),
        .flag_port_a_o(pa), .flag_port_b_o(pb), .flag_port_c_o(pc), .flag_port_d_o(pd));
    ////////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task chk(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task w(int n);
        repeat (n) @(posedge clk_i);
    endtask : w
    task wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(logic [7:0] a, logic [31:0] exp);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        chk("rdata", rdata, exp);
    endtask : rd_reg
    task pulse(packet_event_t p);
        @(posedge clk_i);
        pk <= p;
        @(posedge clk_i);
        pk <= '0;
    endtask : pulse
    task tok(logic [6:0] a);
        pulse('{token_done: 1'b1, token_crc5_ok: 1'b1, token_pid_ok: 1'b1, token_address: a,
            token_endpoint: 4'h5, default: '0});
    endtask : tok
    // a hang counts as a failure rather than stalling the run
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        w(12);
        rst_n_i <= 1'b1;
        rd_reg(OFS_OTG_POWER_CONTROL, 32'h0000_0000);
        rd_reg(OFS_SERIAL_LINE_CTRL, 32'h0000_0052);
        wr_reg(OFS_OTG_POWER_CONTROL, 32'hffff_ffff);
        rd_reg(OFS_OTG_POWER_CONTROL, 32'h0000_00df);
        chk("otg ctrl", {25'h0, ctrl[10:4]}, 32'h0000_007f);
        w(1);
        otg <= 6'h2d;
        w(5);
        rd_reg(OFS_OTG_STATUS_MIRROR, 32'h0000_002d);
        rd_reg(OFS_LINE_ERROR_FLAGS, 32'h0000_0008);
        wr_reg(OFS_SERIAL_LINE_CTRL, 32'h0000_0004);
        w(5);
        rd_reg(OFS_SERIAL_LINE_CTRL, 32'h0000_0054);
        chk("serial ctrl", {28'h0, ctrl[3:0]}, 32'h0000_0004);
        wr_reg(OFS_SERIAL_LINE_CTRL, 32'h0000_000d);
        w(5);
        chk("serial ctrl", {28'h0, ctrl[3:0]}, 32'h0000_000d);
        w(1);
        rx <= 2'h3;
        w(5);
        rd_reg(OFS_LINE_ERROR_FLAGS, 32'h0000_0023);
        w(1);
        rx <= 2'h0;
        wr_reg(OFS_FLAG_PORT_ROUTING, 32'h0404_4040);
        wr_reg(OFS_ENDPOINT_MARK, 32'h0000_0020);
        w(5);
        tok(7'h2b);
        rd_reg(OFS_LINE_ERROR_FLAGS, 32'h0000_0020);
        tok(7'h2a);
        rd_reg(OFS_LINE_ERROR_FLAGS, 32'h0000_0060);
        chk("ports", {28'h0, pa, pb, pc, pd}, 32'h0000_000c);
        rd_reg(OFS_LAST_ENDPOINT, 32'h0000_0015);
        chk("rx endpoint", {26'h0, epv, ep}, 32'h0000_0035);
        pulse('{data_crc16_fail: 1'b1, default: '0});
        rd_reg(OFS_LINE_ERROR_FLAGS, 32'h0000_0064);
        chk("ports", {28'h0, pa, pb, pc, pd}, 32'h0000_000f);
        pulse('{packet_start: 1'b1, default: '0});
        rd_reg(OFS_LINE_ERROR_FLAGS, 32'h0000_0020);
        wr_reg(OFS_FLAG_HOLD_SELECT, 32'h0000_0040);
        tok(7'h2a);
        pulse('{packet_start: 1'b1, default: '0});
        rd_reg(OFS_LINE_ERROR_FLAGS, 32'h0000_0060);
        wr_reg(OFS_LINE_ERROR_FLAGS, 32'h0000_0040);
        rd_reg(OFS_LINE_ERROR_FLAGS, 32'h0000_0020);
        pulse('{pid_valid: 1'b1, pid: 4'h9, default: '0});
        rd_reg(OFS_LAST_PACKET_ID, 32'h0000_0009);
        pulse('{sof_valid: 1'b1, sof_frame: 11'h123, default: '0});
        rd_reg(OFS_FRAME_NUMBER, 32'h0000_0123);
        wr_reg(OFS_POWER_SIGNAL_WORD, 32'hffff_ffff);
        rd_reg(OFS_POWER_SIGNAL_WORD, 32'h0000_01ff);
        wr_reg(OFS_FRAME_NUMBER, 32'hffff_ffff);
        rd_reg(OFS_FRAME_NUMBER, 32'h0000_07ff);
        rd_reg(8'h44, 32'h0000_0000);
        wr_reg(OFS_MODULE_RESET, 32'h0000_0000);
        rd_reg(OFS_OTG_POWER_CONTROL, 32'h0000_0000);
        rd_reg(OFS_FRAME_NUMBER, 32'h0000_0000);
        give_verdict();
    end
endmodule : usb_phy_interface_regs_tb_top

// ### tb/usb_xcvr_model.sv
// behavioural transceiver answering the serial line controls
`timescale 1ns/1ps
module usb_xcvr_model
    import usb_phy_regs_pkg::*;
(
    input  wire utmi_ctrl_t  ctrl_i,
    input  wire otg_status_t otg_i,
    input  wire logic [1:0]  rx_i,
    output utmi_status_t     status_o
);
    // idle bus rests at j; while transmitting the driven data loops back
    wire logic tx_on = !ctrl_i.transmit_enable_low;
    wire logic se0   = tx_on && ctrl_i.transmit_single_ended_zero;
    wire logic dp    = tx_on ? (ctrl_i.serial_transmit_value && !se0) : 1'b1;
    wire logic dm    = tx_on ? (!ctrl_i.serial_transmit_value && !se0) : 1'b0;
    assign status_o = '{otg: otg_i, differential_receive_value: dp, minus_line_receive: dm,
        plus_line_receive: dp, receive_active_input: rx_i[1], receive_error_input: rx_i[0],
        line_state: se0 ? LS_SE0 : (dp ? LS_J : LS_K)};
endmodule : usb_xcvr_model
